// ---- flow_pulse_totalizer_test.sv ----
`timescale 1ns/1ps
module flow_pulse_totalizer_test import fpt_pkg::*;;
   logic pclk;
   logic presetn;
   fpt_apb_req_t apb;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sensor_pulse;
   fpt_alarm_t alarms;
   logic strap;
   logic [NUM_OUT-1:0] iso_out;
   logic [15:0] aout_volt_mv;
   logic [15:0] aout_cur_ua;
   logic [15:0] period;
   logic [31:0] rd;
   logic er;
   int n_mismatch = 0;
   int checks = 0;
   logic [7:0] ra[6] = '{OFF_CTRL, OFF_EVENT, OFF_STOP, OFF_FUNC, OFF_DAMP,
      OFF_TOTAL};
   logic [7:0] ca[6] = '{OFF_START, OFF_CUTOFF, OFF_INTERVAL, OFF_INTERVAL,
      OFF_DAMP, OFF_FUNC};
   logic [31:0] cw[6] = '{32'h7d0, 32'hc8, 32'h64, 32'h1_1170, 32'hc8, 32'hbb};
   logic [31:0] ce[6] = '{32'h3e8, 32'h64, 32'h1f4, 32'hea60, 32'h63, 32'h0};
   fpt_alarm_t pat[3] = '{6'h2a, 6'h15, 6'h0};

   fpt_top #(.TICK_CYC(20), .CONFIRM_CYC(50), .PW_TIMEOUT_CYC(100)) uut (
      .pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sensor_pulse(sensor_pulse),
      .alarms(alarms), .temperature_probe_option(strap), .iso_out(iso_out),
      .aout_volt_mv(aout_volt_mv), .aout_cur_ua(aout_cur_ua)
   );
   fpt_wheel wheel (.pclk(pclk), .period(period), .sensor_pulse(sensor_pulse));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // An idle cycle follows every transfer so no signal is driven twice
   // in one time step.
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      apb <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
      @(posedge pclk);
      if (n >= 50) begin
         n_mismatch++;
         wrap_up();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      check(rd, e);
   endtask

   task automatic wait_out(input logic v, input logic [15:0] e);
      int n;
      n = 0;
      while ((v ? aout_volt_mv : 16'(iso_out)) !== e && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      check(v ? 32'(aout_volt_mv) : 32'(iso_out), 32'(e));
      if (n >= 2000) begin
         wrap_up();
      end
   endtask

   task automatic fset(input logic [31:0] v, input logic [1:0] e);
      wr(OFF_FUNC, v);
      repeat (2) @(posedge pclk);
      check(32'(iso_out), 32'(e));
   endtask

   function automatic logic fexp(input logic [3:0] f, input fpt_alarm_t a);
      case (f)
         4'h1: return a.flow_low;
         4'h2: return a.flow_high;
         4'h3: return !a.flow_low && !a.flow_high;
         4'h4: return a.main_over;
         4'h6: return a.temp_low && strap;
         4'h7: return a.temp_high && strap;
         4'h8: return !a.temp_low && !a.temp_high && strap;
         4'h9: return a.diag;
         default: return 1'b0;
      endcase
   endfunction

   task automatic sweep;
      for (int f = 0; f < 10; f++) begin
         for (int p = 0; p < 3; p++) begin
            alarms <= pat[p];
            fset(32'(f) << 4, {fexp(4'(f), pat[p]), 1'b0});
         end
      end
   endtask

   task automatic do_reset(input logic s);
      presetn <= 1'b0;
      strap <= s;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask

   initial begin
      apb = '0;
      alarms = '0;
      period = 16'h0;
      do_reset(1'b0);
      foreach (ra[i]) begin
         rchk(ra[i], ra[i] == OFF_DAMP ? 32'h5 : 32'h0);
      end
      foreach (ca[i]) begin
         wr(ca[i], cw[i]);
         rchk(ca[i], ce[i]);
      end
      xfer(1'b0, 8'h40, 32'h0);
      check(32'(er), 32'h1);
      wr(OFF_DAMP, 32'h0);
      wr(OFF_CAL, 32'hc350);
      wr(OFF_FS, 32'hc350);
      period <= 16'h14;
      wait_out(1'b1, 16'h05dc);
      check(32'(aout_cur_ua), 32'h2260);
      rchk(OFF_FLOW, 32'h12c);
      wr(OFF_CTRL, 32'h1);
      repeat (80) @(posedge pclk);
      rchk(OFF_TOTAL, 32'h0);
      wr(OFF_EVENT, 32'h01c9_c380);
      wr(OFF_FUNC, 32'h5);
      wr(OFF_START, 32'h12c);
      wait_out(1'b0, 16'h1);
      xfer(1'b0, OFF_TOTAL, 32'h0);
      check(rd % 32'h00e4_e1c0, 32'h0);
      wr(OFF_CTRL, 32'h4);
      repeat (60) @(posedge pclk);
      wr(OFF_CTRL, 32'h4);
      xfer(1'b0, OFF_TOTAL, 32'h0);
      check(32'(rd == 32'h0), 32'h0);
      wr(OFF_CTRL, 32'h4);
      rchk(OFF_TOTAL, 32'h0);
      wait_out(1'b0, 16'h0);
      period <= 16'h3c;
      wait_out(1'b1, 16'h01f4);
      period <= 16'h4b;
      wait_out(1'b1, 16'h0);
      check(32'(aout_cur_ua), 32'hfa0);
      period <= 16'h3c;
      repeat (400) @(posedge pclk);
      check(32'(aout_volt_mv), 32'h0);
      period <= 16'h32;
      wait_out(1'b1, 16'h0258);
      sweep();
      fset(32'ha0, 2'b10);
      fset(32'h10, 2'b10);
      fset(32'h0, 2'b00);
      wr(OFF_START, 32'h0);
      wr(OFF_CTRL, 32'h1);
      repeat (60) @(posedge pclk);
      xfer(1'b0, OFF_TOTAL, 32'h0);
      check(32'(rd == 32'h0), 32'h0);
      wr(OFF_CTRL, 32'h2);
      rchk(OFF_CTRL, 32'h2);
      do_reset(1'b1);
      rchk(OFF_TOTAL, 32'h0);
      rchk(OFF_CTRL, 32'h0);
      sweep();
      wrap_up();
   end
endmodule

// ---- fpt_asserts.sv ----
`timescale 1ns/1ps
module fpt_chk import fpt_pkg::*; #(
   parameter int unsigned TICK_CYC = TICK_CYCLES,
   parameter int unsigned CONFIRM_CYC = CONFIRM_CYCLES,
   parameter int unsigned PW_TIMEOUT_CYC = PW_TIMEOUT_CYCLES
) (
   input logic pclk,
   input logic presetn,
   input fpt_apb_req_t apb,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic sensor_pulse,
   input fpt_alarm_t alarms,
   input logic temperature_probe_option,
   input logic [NUM_OUT-1:0] iso_out,
   input logic [15:0] aout_volt_mv,
   input logic [15:0] aout_cur_ua
);
   logic [3:0] fn1;
   logic lat1;
   logic man;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Only the second output is shadowed, since the first one depends on
   // the pilot total, which is not visible at the ports.
   assign man = fn1 == 4'ha || (lat1 && fn1 != 4'h0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fn1 <= 4'h0;
         lat1 <= 1'b0;
      end else begin
         lat1 <= man;
         if (apb.psel && apb.penable && pready && apb.pwrite &&
            apb.paddr == OFF_FUNC) begin
            fn1 <= (apb.pwdata[7:4] > 4'ha) ? 4'h0 : apb.pwdata[7:4];
         end
      end
   end
   property p_err;
      apb.psel && !apb.penable && apb.paddr > OFF_TOTAL |=>
         pready && pslverr && prdata == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_cut;
      aout_cur_ua == 16'hfa0 |-> aout_volt_mv == 16'h0;
   endproperty
   a_cut: assert property (p_cut) else $error("volt not zero");
   property p_scale;
      aout_volt_mv != 16'h0 && aout_volt_mv < 16'h4000 |->
         32'(aout_cur_ua) == 32'(aout_volt_mv) / AOUT_MV_PER_PM *
         AOUT_UA_PER_PM + AOUT_UA_ZERO;
   endproperty
   a_scale: assert property (p_scale) else $error("aout mismatch");
   property p_off;
      $past(fn1) == 4'h0 |-> !iso_out[1];
   endproperty
   a_off: assert property (p_off) else $error("disabled out on");
   property p_band;
      $past(fn1) == FN_FLOW_BAND && !$past(man) |-> iso_out[1] ==
         (!$past(alarms.flow_low) && !$past(alarms.flow_high));
   endproperty
   a_band: assert property (p_band) else $error("band out wrong");
   property p_diag;
      $past(fn1) == FN_DIAG && !$past(man) |->
         iso_out[1] == $past(alarms.diag);
   endproperty
   a_diag: assert property (p_diag) else $error("diag out wrong");
   property p_temp;
      $past(fn1) == FN_TEMP_HIGH && !$past(man) |-> iso_out[1] ==
         ($past(alarms.temp_high) && $past(temperature_probe_option));
   endproperty
   a_temp: assert property (p_temp) else $error("temp out wrong");
   property p_man;
      $past(man) |-> iso_out[1];
   endproperty
   a_man: assert property (p_man) else $error("manual out off");
   c_err: cover property (pready && pslverr);
   c_man: cover property ($past(man) && iso_out[1]);
   c_cut: cover property ($fell(aout_volt_mv != 16'h0));
endmodule

bind fpt_top fpt_chk #(
   .TICK_CYC(TICK_CYC),
   .CONFIRM_CYC(CONFIRM_CYC),
   .PW_TIMEOUT_CYC(PW_TIMEOUT_CYC)
) chk (
   .pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sensor_pulse(sensor_pulse),
   .alarms(alarms), .temperature_probe_option(temperature_probe_option),
   .iso_out(iso_out), .aout_volt_mv(aout_volt_mv), .aout_cur_ua(aout_cur_ua)
);

// ---- fpt_divider.sv ----
`timescale 1ns/1ps
module fpt_divider import fpt_pkg::*; (
   input logic pclk,
   input logic presetn,
   input logic start,
   input logic [63:0] numer,
   input logic [63:0] denom,
   output logic done,
   output logic [63:0] quot
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [5:0] cnt;
      logic [64:0] rem;
      logic [63:0] quo;
      logic [63:0] den;
   } fpt_div_t;

   fpt_div_t s;
   fpt_div_t next_s;
   logic [64:0] shifted;
   logic fits;

   assign shifted = {s.rem[63:0], s.quo[63]};
   assign fits = shifted >= {1'b0, s.den};
   assign done = s.done;
   assign quot = s.quo;

   // Restoring division, one quotient bit per clock.
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (start && !s.busy) begin
         next_s.busy = 1'b1;
         next_s.cnt = '0;
         next_s.rem = '0;
         next_s.quo = numer;
         next_s.den = denom;
      end else if (s.busy) begin
         next_s.rem = fits ? shifted - {1'b0, s.den} : shifted;
         next_s.quo = {s.quo[62:0], fits};
         next_s.cnt = s.cnt + 6'd1;
         if (s.cnt == 6'h3f) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ---- fpt_pkg.sv ----
package fpt_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned UPDATE_MS = 100;
   localparam int unsigned CONFIRM_S = 2;
   localparam int unsigned PW_TIMEOUT_MS = 1000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned TICK_CYCLES = CYC_PER_MS * UPDATE_MS;
   localparam int unsigned CONFIRM_CYCLES = CLK_HZ * CONFIRM_S;
   localparam int unsigned PW_TIMEOUT_CYCLES = CYC_PER_MS * PW_TIMEOUT_MS;
   // Flow is carried in tenths of a percent of full scale.
   localparam logic [63:0] PW_NUMER = 64'(CLK_HZ) * 64'd60_000;
   localparam logic [31:0] CNT_SCALE = 32'd60_000_000;
   localparam logic [15:0] HYST_PM = 16'h000a;
   localparam logic [6:0] CUTOFF_MAX = 7'h64;
   localparam logic [9:0] START_MAX = 10'h3e8;
   localparam logic [15:0] INTERVAL_MIN = 16'h01f4;
   localparam logic [15:0] INTERVAL_MAX = 16'hea60;
   localparam logic [6:0] DAMP_MAX = 7'h63;
   localparam logic [6:0] DAMP_RST = 7'h05;
   localparam logic [15:0] INTERVAL_RST = 16'h0fa0;
   localparam logic [15:0] CAL_RST = 16'h03e8;
   localparam logic [15:0] FS_RST = 16'h000a;
   localparam logic [9:0] TICKS_PER_S = 10'h00a;
   localparam logic [31:0] AOUT_MV_PER_PM = 32'h0000_0005;
   localparam logic [31:0] AOUT_UA_PER_PM = 32'h0000_0010;
   localparam logic [31:0] AOUT_UA_ZERO = 32'h0000_0fa0;
   localparam logic [31:0] SAT16 = 32'h0000_ffff;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_START = 8'h04;
   localparam logic [7:0] OFF_EVENT = 8'h08;
   localparam logic [7:0] OFF_STOP = 8'h0c;
   localparam logic [7:0] OFF_FUNC = 8'h10;
   localparam logic [7:0] OFF_CUTOFF = 8'h14;
   localparam logic [7:0] OFF_INTERVAL = 8'h18;
   localparam logic [7:0] OFF_CAL = 8'h1c;
   localparam logic [7:0] OFF_DAMP = 8'h20;
   localparam logic [7:0] OFF_FS = 8'h24;
   localparam logic [7:0] OFF_STATUS = 8'h28;
   localparam logic [7:0] OFF_FLOW = 8'h2c;
   localparam logic [7:0] OFF_TOTAL = 8'h30;
   localparam int CTRL_EN = 0;
   localparam int CTRL_COUNT = 1;
   localparam int CTRL_CONFIRM = 2;
   localparam int FUNC_W = 4;
   localparam int NUM_OUT = 2;

   typedef enum logic [3:0] {
      FN_DISABLED, FN_LOW_FLOW, FN_HIGH_FLOW, FN_FLOW_BAND, FN_MAIN_OVER,
      FN_PILOT_OVER, FN_TEMP_LOW, FN_TEMP_HIGH, FN_TEMP_BAND, FN_DIAG,
      FN_MANUAL
   } fpt_func_t;

   typedef struct packed {
      logic flow_low;
      logic flow_high;
      logic main_over;
      logic temp_low;
      logic temp_high;
      logic diag;
   } fpt_alarm_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } fpt_apb_req_t;
endpackage

// ---- fpt_smoother.sv ----
`timescale 1ns/1ps
module fpt_smoother import fpt_pkg::*; (
   input logic pclk,
   input logic presetn,
   input logic tick,
   input logic bypass,
   input logic [6:0] damping,
   input logic [15:0] sample,
   output logic [15:0] smooth
);
   typedef struct packed {
      logic [23:0] acc;
   } fpt_smooth_t;

   fpt_smooth_t s;
   fpt_smooth_t next_s;
   logic [9:0] span;
   logic [3:0] shift;
   logic signed [24:0] diff;

   // The averaging span is the damping time in update periods; a shift
   // by its log2 replaces a divider at the cost of coarse steps.
   function automatic logic [3:0] log2_floor(input logic [9:0] v);
      logic [3:0] r;
      r = '0;
      for (int i = 0; i < 10; i++) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   assign span = 10'(damping) * TICKS_PER_S;
   assign shift = log2_floor(span);
   assign diff = $signed({1'b0, sample, 8'h00}) - $signed({1'b0, s.acc});
   assign smooth = s.acc[23:8];

   always_comb begin
      next_s = s;
      if (bypass) begin
         next_s.acc = {sample, 8'h00};
      end else if (tick) begin
         next_s.acc = 24'($signed({1'b0, s.acc}) + (diff >>> shift));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ---- fpt_top.sv ----
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module fpt_top import fpt_pkg::*; #(
   parameter int unsigned TICK_CYC = TICK_CYCLES,
   parameter int unsigned CONFIRM_CYC = CONFIRM_CYCLES,
   parameter int unsigned PW_TIMEOUT_CYC = PW_TIMEOUT_CYCLES
) (
   input logic pclk,
   input logic presetn,
   input fpt_apb_req_t apb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input logic sensor_pulse,
   input fpt_alarm_t alarms,
   input logic temperature_probe_option,
   output logic [NUM_OUT-1:0] iso_out,
   output logic [15:0] aout_volt_mv,
   output logic [15:0] aout_cur_ua
);
   typedef struct packed {
      logic [2:0] sync;
      logic pulse;
      logic [27:0] pw_cnt;
      logic [31:0] pulses;
      logic [7:0] ms_pre;
      logic [15:0] ms_cnt;
      logic div_go;
      logic [63:0] numer;
      logic [63:0] denom;
      logic [15:0] raw_pm;
      logic [31:0] tick_cnt;
      logic tick;
      logic cut;
      logic [15:0] flow_pm;
      logic [31:0] total;
      logic pilot_over;
      logic win_open;
      logic [31:0] win_cnt;
      logic en;
      logic count_mode;
      logic [9:0] start_pm;
      logic [31:0] event_vol;
      logic [31:0] stop_vol;
      fpt_func_t [NUM_OUT-1:0] func;
      logic [6:0] cutoff_pm;
      logic [15:0] interval_ms;
      logic [15:0] cal;
      logic [6:0] damping;
      logic [15:0] fs_gpm;
      logic [NUM_OUT-1:0] manual;
      logic [NUM_OUT-1:0] iso;
      logic [15:0] aout_mv;
      logic [15:0] aout_ua;
      logic temp_opt;
      logic strap_done;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } fpt_state_t;

   fpt_state_t s;
   fpt_state_t next_s;

   logic rise;
   logic access;
   logic wr;
   logic div_done;
   logic [63:0] quot;
   logic [15:0] smooth_pm;
   logic [31:0] base;
   logic [31:0] add;
   logic [31:0] sum;
   logic accumulate;
   logic crossed;
   logic confirm;
   logic [15:0] cut_hi;
   logic [31:0] mv;
   logic [31:0] ua;
   logic [63:0] cal_fs;
   logic [NUM_OUT-1:0] src;
   logic [NUM_OUT-1:0] next_manual;
   logic [31:0] rd;
   logic rd_err;

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign iso_out = s.iso;
   assign aout_volt_mv = s.aout_mv;
   assign aout_cur_ua = s.aout_ua;

   // A level counts once the second and third flops agree.
   assign rise = (s.sync[1] == s.sync[2]) && s.sync[2] && !s.pulse;
   assign access = apb.psel && apb.penable && s.pready;
   assign wr = access && apb.pwrite;
   assign confirm = wr && apb.paddr == OFF_CTRL && apb.pwdata[CTRL_CONFIRM];
   assign cal_fs = 64'(s.cal) * 64'(s.fs_gpm);

   fpt_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .start(s.div_go),
      .numer(s.numer),
      .denom(s.denom),
      .done(div_done),
      .quot(quot)
   );

   // Pulse counting already averages over its interval, so the filter
   // is bypassed there.
   fpt_smoother u_noise_smoothing (
      .pclk(pclk),
      .presetn(presetn),
      .tick(s.tick),
      .bypass(s.count_mode || s.damping == '0),
      .damping(s.damping),
      .sample(s.raw_pm),
      .smooth(smooth_pm)
   );

   assign cut_hi = 16'(s.cutoff_pm) + HYST_PM;
   assign base = (confirm && s.win_open) ? '0 : s.total;
   assign add = 32'(s.flow_pm) * 32'(s.fs_gpm);
   assign sum = base + add;
   assign accumulate = s.tick && s.en && !s.cut
      && s.flow_pm >= 16'(s.start_pm)
      && (s.stop_vol == '0 || base < s.stop_vol);
   assign crossed = accumulate && s.event_vol != '0
      && base < s.event_vol && sum >= s.event_vol;
   assign mv = 32'(s.flow_pm) * AOUT_MV_PER_PM;
   assign ua = AOUT_UA_ZERO + 32'(s.flow_pm) * AOUT_UA_PER_PM;

   generate
      for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
         always_comb begin
            next_manual[i] = s.manual[i];
            if (s.func[i] == FN_MANUAL) begin
               next_manual[i] = 1'b1;
            end else if (s.func[i] == FN_DISABLED) begin
               next_manual[i] = 1'b0;
            end
            case (s.func[i])
               FN_DISABLED: src[i] = 1'b0;
               FN_LOW_FLOW: src[i] = alarms.flow_low;
               FN_HIGH_FLOW: src[i] = alarms.flow_high;
               FN_FLOW_BAND: src[i] = !alarms.flow_low && !alarms.flow_high;
               FN_MAIN_OVER: src[i] = alarms.main_over;
               FN_PILOT_OVER: src[i] = s.pilot_over;
               FN_TEMP_LOW: src[i] = s.temp_opt && alarms.temp_low;
               FN_TEMP_HIGH: src[i] = s.temp_opt && alarms.temp_high;
               FN_TEMP_BAND: src[i] = s.temp_opt && !alarms.temp_low
                  && !alarms.temp_high;
               FN_DIAG: src[i] = alarms.diag;
               FN_MANUAL: src[i] = 1'b1;
               default: src[i] = 1'b0;
            endcase
            if (s.func[i] != FN_DISABLED && s.manual[i]) begin
               src[i] = 1'b1;
            end
         end
      end
   endgenerate

   always_comb begin
      rd_err = 1'b0;
      case (apb.paddr)
         OFF_CTRL: rd = {30'h0, s.count_mode, s.en};
         OFF_START: rd = 32'(s.start_pm);
         OFF_EVENT: rd = s.event_vol;
         OFF_STOP: rd = s.stop_vol;
         OFF_FUNC: rd = 32'({s.func[1], s.func[0]});
         OFF_CUTOFF: rd = 32'(s.cutoff_pm);
         OFF_INTERVAL: rd = 32'(s.interval_ms);
         OFF_CAL: rd = 32'(s.cal);
         OFF_DAMP: rd = 32'(s.damping);
         OFF_FS: rd = 32'(s.fs_gpm);
         OFF_STATUS: rd = 32'({s.win_open, s.pilot_over, s.cut,
            s.temp_opt, s.iso});
         OFF_FLOW: rd = 32'(s.flow_pm);
         OFF_TOTAL: rd = s.total;
         default: begin
            rd = '0;
            rd_err = 1'b1;
         end
      endcase
   end

   always_comb begin
      next_s = s;
      next_s.sync = {s.sync[1:0], sensor_pulse};
      if (s.sync[1] == s.sync[2]) begin
         next_s.pulse = s.sync[2];
      end
      if (!s.strap_done) begin
         next_s.strap_done = 1'b1;
         next_s.temp_opt = temperature_probe_option;
      end

      // Bus slave: answer is prepared in setup, presented in access.
      next_s.pready = apb.psel && !apb.penable;
      next_s.prdata = '0;
      next_s.pslverr = 1'b0;
      if (apb.psel && !apb.penable) begin
         next_s.prdata = apb.pwrite ? '0 : rd;
         next_s.pslverr = rd_err;
      end
      if (wr) begin
         case (apb.paddr)
            OFF_CTRL: begin
               next_s.en = apb.pwdata[CTRL_EN];
               next_s.count_mode = apb.pwdata[CTRL_COUNT];
            end
            OFF_START: next_s.start_pm = (apb.pwdata > 32'(START_MAX))
               ? START_MAX : apb.pwdata[9:0];
            OFF_EVENT: next_s.event_vol = apb.pwdata;
            OFF_STOP: next_s.stop_vol = apb.pwdata;
            OFF_FUNC: begin
               for (int i = 0; i < NUM_OUT; i++) begin
                  next_s.func[i] = (apb.pwdata[i*FUNC_W +: FUNC_W]
                     > FN_MANUAL) ? FN_DISABLED
                     : fpt_func_t'(apb.pwdata[i*FUNC_W +: FUNC_W]);
               end
            end
            OFF_CUTOFF: next_s.cutoff_pm = (apb.pwdata > 32'(CUTOFF_MAX))
               ? CUTOFF_MAX : apb.pwdata[6:0];
            OFF_INTERVAL: begin
               if (apb.pwdata < 32'(INTERVAL_MIN)) begin
                  next_s.interval_ms = INTERVAL_MIN;
               end else if (apb.pwdata > 32'(INTERVAL_MAX)) begin
                  next_s.interval_ms = INTERVAL_MAX;
               end else begin
                  next_s.interval_ms = apb.pwdata[15:0];
               end
            end
            OFF_CAL: next_s.cal = apb.pwdata[15:0];
            OFF_DAMP: next_s.damping = (apb.pwdata > 32'(DAMP_MAX))
               ? DAMP_MAX : apb.pwdata[6:0];
            OFF_FS: next_s.fs_gpm = apb.pwdata[15:0];
            default: begin
            end
         endcase
      end

      // Frequency measurement feeding one shared divider.
      next_s.div_go = 1'b0;
      if (s.count_mode) begin
         next_s.pw_cnt = '0;
         if (rise) begin
            next_s.pulses = s.pulses + 32'd1;
         end
         if (s.ms_pre == 8'(CYC_PER_MS - 1)) begin
            next_s.ms_pre = '0;
            next_s.ms_cnt = s.ms_cnt + 16'd1;
            if (s.ms_cnt + 16'd1 >= s.interval_ms) begin
               next_s.ms_cnt = '0;
               next_s.pulses = '0;
               next_s.numer = 64'(s.pulses) * 64'(CNT_SCALE);
               next_s.denom = 64'(s.interval_ms) * cal_fs;
               next_s.div_go = 1'b1;
            end
         end else begin
            next_s.ms_pre = s.ms_pre + 8'd1;
         end
      end else begin
         next_s.pulses = '0;
         next_s.ms_pre = '0;
         next_s.ms_cnt = '0;
         if (rise) begin
            next_s.pw_cnt = 28'd1;
            next_s.numer = PW_NUMER;
            next_s.denom = 64'(s.pw_cnt) * cal_fs;
            next_s.div_go = 1'b1;
         end else if (s.pw_cnt < 28'(PW_TIMEOUT_CYC)) begin
            next_s.pw_cnt = s.pw_cnt + 28'd1;
         end else begin
            // No pulse for the timeout: the wheel has stopped.
            next_s.raw_pm = '0;
         end
      end
      if (next_s.div_go && next_s.denom == '0) begin
         next_s.div_go = 1'b0;
         next_s.raw_pm = '0;
      end
      if (div_done) begin
         next_s.raw_pm = (quot > 64'(SAT16)) ? 16'hffff : quot[15:0];
      end

      // Update period.
      next_s.tick = 1'b0;
      if (s.tick_cnt == '0) begin
         next_s.tick_cnt = TICK_CYC - 1;
         next_s.tick = 1'b1;
      end else begin
         next_s.tick_cnt = s.tick_cnt - 32'd1;
      end

      // Low-flow cut-off with hysteresis.
      if (s.cutoff_pm == '0) begin
         next_s.cut = 1'b0;
      end else if (s.cut) begin
         next_s.cut = smooth_pm < cut_hi;
      end else begin
         next_s.cut = smooth_pm < 16'(s.cutoff_pm);
      end
      next_s.flow_pm = s.cut ? '0 : smooth_pm;
      next_s.aout_mv = s.cut ? '0 : ((mv > SAT16) ? 16'hffff : mv[15:0]);
      next_s.aout_ua = s.cut ? 16'(AOUT_UA_ZERO)
         : ((ua > SAT16) ? 16'hffff : ua[15:0]);

      // Totalizer and confirmed clear; a crossing in the clearing
      // cycle still sets the over-limit flag.
      next_s.total = base;
      if (confirm && s.win_open) begin
         next_s.pilot_over = 1'b0;
         next_s.win_open = 1'b0;
      end else if (confirm) begin
         next_s.win_open = 1'b1;
         next_s.win_cnt = CONFIRM_CYC - 1;
      end else if (s.win_open) begin
         if (s.win_cnt == '0) begin
            next_s.win_open = 1'b0;
         end else begin
            next_s.win_cnt = s.win_cnt - 32'd1;
         end
      end
      if (accumulate) begin
         next_s.total = sum;
      end
      if (crossed) begin
         next_s.pilot_over = 1'b1;
      end

      next_s.manual = next_manual;
      next_s.iso = src;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.cut <= 1'b1;
         s.damping <= DAMP_RST;
         s.interval_ms <= INTERVAL_RST;
         s.cal <= CAL_RST;
         s.fs_gpm <= FS_RST;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ---- fpt_wheel.sv ----
`timescale 1ns/1ps
module fpt_wheel (
   input wire logic pclk,
   input wire logic [15:0] period,
   output logic sensor_pulse
);
   logic [15:0] cnt = 16'h0;
   initial sensor_pulse = 1'b0;
   // A zero period is a wheel at rest; the sensor then holds its low level.
   always @(posedge pclk) begin
      cnt <= (cnt + 16'h1 >= period) ? 16'h0 : cnt + 16'h1;
      sensor_pulse <= period != 16'h0 && cnt < 16'h4;
   end
endmodule
